// ---- logic/clock_reset_control.sv ----
`timescale 1ns/10ps
`include "clock_reset_defines.svh"

// Contract
// - preset 14-bit countdown, decrement after oscillator stable
// - reset releases at zero, held by pin
// - slow select: 0 prescaled main, 1 oscillator
// - fast select: 0 pll, 1 main, resets 1
// - switch to pll ignored while powered down
// - fast select reads 1 until pll locks
// - pll power-down bit, resets to 1
// - setting power-down ignored while on pll
// - aux clock 1 needs enable and stable main
// - aux clock 2 needs enable and stable main
// - power-on flag cleared by writing 0 only
// - control register bit layout, bits 7:6 reserved
// - system clock divided by divisor plus one
// - fast prescaler resets 4f except programming mode
// - multiplier codes 3,4,5; reset code 100
// - four registers at fffc40 to fffc46
module clock_reset_control (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic ext_reset_n_i,
   input wire logic osc_stable_i,
   input wire logic main_stable_i,
   input wire logic pll_locked_i,
   input wire logic slow_osc_tick_i,
   input wire logic programming_mode_i,
   input wire logic [`CRC_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic int_reset_o,
   output logic pll_power_down_o,
   output logic [2:0] pll_mul_o,
   output logic fast_source_select_o,
   output logic slow_source_select_o,
   output logic sys_clk_en_o,
   output logic slow_clk_en_o,
   output logic aux1_clk_en_o,
   output logic aux2_clk_en_o
);
   // ==========================================================
   // register state
   logic slow_sel;
   logic fast_source_select;
   logic pll_power_down;
   logic aux1_enable;
   logic aux2_enable;
   logic por_flag;
   logic [7:0] fast_clock_prescaler;
   logic [7:0] slow_clock_prescaler;
   logic [7:0] aux_clock_prescaler;
   logic slow_half;

   // ==========================================================
   // address decode
   wire hit_ctrl = (addr_i == `CRC_OFF_CTRL);
   wire hit_fast = (addr_i == `CRC_OFF_FAST);
   wire hit_slow = (addr_i == `CRC_OFF_SLOW);
   wire hit_aux = (addr_i == `CRC_OFF_AUX);
   wire wr_ctrl = wr_i && hit_ctrl;
   wire wr_fast = wr_i && hit_fast;
   wire wr_slow = wr_i && hit_slow;
   wire wr_aux = wr_i && hit_aux;

   // ==========================================================
   // control write qualification
   wire w_slow = wdata_i[`CRC_BIT_SLOW_SEL];
   wire w_fast = wdata_i[`CRC_BIT_FAST_SEL];
   wire w_pwd = wdata_i[`CRC_BIT_PLL_PWD];
   wire w_por = wdata_i[`CRC_BIT_POR];
   // request to leave main clock is ignored unless pll is on and locked
   wire fast_clear_ok = !pll_power_down && pll_locked_i;
   // powering down is refused while running from the pll
   wire pwd_set_ok = fast_source_select;
   wire next_fast_sel = w_fast ? 1'b1 : (fast_clear_ok ? 1'b0 : fast_source_select);
   wire next_pwd = w_pwd ? (pwd_set_ok ? 1'b1 : pll_power_down) : 1'b0;

   // ==========================================================
   // control register; por flag is set by hardware, cleared by 0
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         slow_sel <= 1'b0;
         fast_source_select <= 1'b1;
         pll_power_down <= 1'b1;
         aux1_enable <= 1'b0;
         aux2_enable <= 1'b0;
         por_flag <= 1'b1;
      end else if (wr_ctrl) begin
         slow_sel <= w_slow;
         fast_source_select <= next_fast_sel;
         pll_power_down <= next_pwd;
         aux1_enable <= wdata_i[`CRC_BIT_AUX1_EN];
         aux2_enable <= wdata_i[`CRC_BIT_AUX2_EN];
         if (!w_por) begin
            por_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // prescaler registers; programming mode skips the pll preset
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         fast_clock_prescaler <= programming_mode_i ? `CRC_FAST_PROGRAMMING_MODE_RESET
                                                    : `CRC_FAST_RESET;
         slow_clock_prescaler <= `CRC_SLOW_RESET;
         aux_clock_prescaler <= `CRC_AUX_RESET;
      end else begin
         if (wr_fast) begin
            fast_clock_prescaler <= {1'b0, wdata_i[6:0]};
         end
         if (wr_slow) begin
            slow_clock_prescaler <= wdata_i;
         end
         if (wr_aux) begin
            aux_clock_prescaler <= wdata_i;
         end
      end
   end

   // ==========================================================
   // read path: data stand one cycle after the strobe
   wire [7:0] ctrl_view = {2'b00, por_flag, aux2_enable, aux1_enable,
                           pll_power_down, fast_source_select, slow_sel};
   wire [7:0] read_mux = hit_ctrl ? ctrl_view :
                         hit_fast ? fast_clock_prescaler :
                         hit_slow ? slow_clock_prescaler :
                         hit_aux ? aux_clock_prescaler : 8'h00;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? read_mux : 8'h00;
      end
   end

   // ==========================================================
   // reset sequencing
   por_sequencer u_por (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .osc_stable_i(osc_stable_i),
      .ext_reset_n_i(ext_reset_n_i),
      .int_reset_o(int_reset_o),
      .count_o()
   );

   // ==========================================================
   // clock enables; pll path modelled as a tick on every main clock cycle
   wire fast_tick = 1'b1; // one enable per main clock cycle feeds the divider
   clock_divider #(.WIDTH(4)) u_sys_div (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .run_i(1'b1),
      .tick_i(fast_tick),
      .div_i(fast_clock_prescaler[`CRC_DIV_MSB:`CRC_DIV_LSB]),
      .pulse_o(sys_clk_en_o)
   );

   // slow prescaler: fixed divide by two, then divisor plus one
   wire slow_pre_pulse;
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         slow_half <= 1'b0;
      end else begin
         slow_half <= !slow_half;
      end
   end
   clock_divider #(.WIDTH(8)) u_slow_div (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .run_i(!slow_sel),
      .tick_i(slow_half),
      .div_i(slow_clock_prescaler),
      .pulse_o(slow_pre_pulse)
   );
   assign slow_clk_en_o = slow_sel ? slow_osc_tick_i : slow_pre_pulse;

   // aux clocks stop while disabled or the main clock is unstable
   wire aux1_run = aux1_enable && main_stable_i;
   wire aux2_run = aux2_enable && main_stable_i;
   clock_divider #(.WIDTH(4)) u_aux1_div (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .run_i(aux1_run),
      .tick_i(1'b1),
      .div_i(aux_clock_prescaler[3:0]),
      .pulse_o(aux1_clk_en_o)
   );
   clock_divider #(.WIDTH(4)) u_aux2_div (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .run_i(aux2_run),
      .tick_i(1'b1),
      .div_i(aux_clock_prescaler[7:4]),
      .pulse_o(aux2_clk_en_o)
   );

   // ==========================================================
   // pll controls straight from the registers
   assign pll_power_down_o = pll_power_down;
   assign pll_mul_o = fast_clock_prescaler[`CRC_MUL_MSB:`CRC_MUL_LSB];
   assign fast_source_select_o = fast_source_select;
   assign slow_source_select_o = slow_sel;
endmodule // clock_reset_control

// ---- logic/clock_reset_defines.svh ----
`ifndef CLOCK_RESET_DEFINES_SVH
`define CLOCK_RESET_DEFINES_SVH

// ==========================================================
// register byte addresses (24-bit bus address)
`define CRC_ADDR_W 24
`define CRC_OFF_CTRL 24'hfffc40
`define CRC_OFF_FAST 24'hfffc42
`define CRC_OFF_SLOW 24'hfffc44
`define CRC_OFF_AUX 24'hfffc46

// ==========================================================
// control register bit positions
`define CRC_BIT_SLOW_SEL 0
`define CRC_BIT_FAST_SEL 1
`define CRC_BIT_PLL_PWD 2
`define CRC_BIT_AUX1_EN 3
`define CRC_BIT_AUX2_EN 4
`define CRC_BIT_POR 5

// ==========================================================
// fast prescaler fields and reset values
`define CRC_DIV_LSB 0
`define CRC_DIV_MSB 3
`define CRC_MUL_LSB 4
`define CRC_MUL_MSB 6
`define CRC_FAST_RESET 8'h4f
`define CRC_FAST_PROGRAMMING_MODE_RESET 8'h0f
`define CRC_SLOW_RESET 8'hb6
`define CRC_AUX_RESET 8'hff

// ==========================================================
// power-up countdown
`define CRC_POR_W 14
`define CRC_POR_PRESET 14'h3fff

`endif

// ---- logic/clock_reset_pkg.sv ----
package clock_reset_pkg;
   // pll multiplier codes; others are reserved
   typedef enum logic [2:0] {
      mul_x3 = 3'b011,
      mul_x4 = 3'b100,
      mul_x5 = 3'b101
   } pll_mul_e;

   // power-up sequencer states
   typedef enum logic [1:0] {
      por_wait_osc = 2'b00,
      por_count = 2'b01,
      por_done = 2'b10
   } por_state_e;
endpackage

// ---- logic/clock_divider.sv ----
`timescale 1ns/10ps
// ==========================================================
// programmable divider: one-cycle enable every (div+1) ticks
module clock_divider #(
   parameter int WIDTH = 4
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [WIDTH-1:0] div_i,
   output logic pulse_o
);
   logic [WIDTH-1:0] count;
   wire at_end = (count >= div_i);

   // counts source ticks; a stopped divider restarts from zero
   always_ff @(posedge mclk_i) begin
      if (srst_i || !run_i) begin
         count <= '0;
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= tick_i && at_end;
         if (tick_i) begin
            count <= at_end ? '0 : count + 1'b1;
         end
      end
   end
endmodule // clock_divider

// ---- logic/por_sequencer.sv ----
`timescale 1ns/10ps
`include "clock_reset_defines.svh"
// ==========================================================
// power-up countdown and internal reset release
module por_sequencer (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic osc_stable_i,
   input wire logic ext_reset_n_i,
   output logic int_reset_o,
   output logic [`CRC_POR_W-1:0] count_o
);
   clock_reset_pkg::por_state_e state;
   logic release_raw;
   logic release_s1;
   logic release_s2;

   wire at_zero = (count_o == '0);

   // countdown only moves once the oscillator is good
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state <= clock_reset_pkg::por_wait_osc;
         count_o <= `CRC_POR_PRESET;
      end else begin
         unique case (state)
            clock_reset_pkg::por_wait_osc: begin
               if (osc_stable_i) begin
                  state <= clock_reset_pkg::por_count;
               end
            end
            clock_reset_pkg::por_count: begin
               if (at_zero) begin
                  state <= clock_reset_pkg::por_done;
               end else begin
                  count_o <= count_o - 1'b1;
               end
            end
            clock_reset_pkg::por_done: begin
               state <= clock_reset_pkg::por_done;
            end
            default: begin
               state <= clock_reset_pkg::por_wait_osc;
            end
         endcase
      end
   end

   // pin low holds reset regardless of the count
   assign release_raw = (state == clock_reset_pkg::por_done) && ext_reset_n_i;

   // two-stage retime so downstream sees a clean release edge
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         release_s1 <= 1'b0;
         release_s2 <= 1'b0;
      end else begin
         release_s1 <= release_raw;
         release_s2 <= release_s1;
      end
   end

   // assertion is immediate on pin low, release is retimed
   assign int_reset_o = !release_s2 || !ext_reset_n_i;
endmodule // por_sequencer

// ---- tb/clock_reset_control_properties.sv ----
`timescale 1ns/10ps
`include "clock_reset_defines.svh"
// ==========================================================
// port checker for the clock and reset control block
module clock_reset_control_properties (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic ext_reset_n_i,
   input wire logic osc_stable_i,
   input wire logic main_stable_i,
   input wire logic pll_locked_i,
   input wire logic [`CRC_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic int_reset_o,
   input wire logic pll_power_down_o,
   input wire logic fast_source_select_o,
   input wire logic aux1_clk_en_o,
   input wire logic aux2_clk_en_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   wire logic ctrl_wr = wr_i && addr_i == `CRC_OFF_CTRL;
   logic [15:0] up_cnt;
   // cycles with a good oscillator since reset; saturates so it never wraps
   always_ff @(posedge mclk_i) begin
      if (srst_i) up_cnt <= 16'h0000;
      else if (osc_stable_i && up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
   end
   chk_pin_holds_reset: assert property (!ext_reset_n_i |-> int_reset_o)
      else $error("internal reset released while pin low");
   chk_count_early: assert property (up_cnt < 16'h3ff0 |-> int_reset_o)
      else $error("internal reset released before countdown end");
   // the pin must stay high through the two retime stages before release is due
   chk_count_late: assert property ((up_cnt > 16'h4020 && ext_reset_n_i) [*3] |-> !int_reset_o)
      else $error("internal reset stuck after countdown");
   chk_aux1_stopped: assert property (!main_stable_i [*2] |-> !aux1_clk_en_o)
      else $error("aux clock 1 runs without stable main clock");
   chk_aux2_stopped: assert property (!main_stable_i [*2] |-> !aux2_clk_en_o)
      else $error("aux clock 2 runs without stable main clock");
   chk_pll_off_switch: assert property (ctrl_wr && !wdata_i[1] && pll_power_down_o
      |=> fast_source_select_o) else $error("switched to pll while powered down");
   chk_lock_needed: assert property (ctrl_wr && !pll_locked_i && fast_source_select_o
      |=> fast_source_select_o) else $error("switched to unlocked pll");
   chk_pwd_on_pll: assert property (ctrl_wr && wdata_i[2] && !fast_source_select_o
      && !pll_power_down_o |=> !pll_power_down_o) else $error("pll stopped while in use");
   chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read answer");
   chk_ctrl_reserved: assert property (rd_i && addr_i == `CRC_OFF_CTRL
      |=> rdata_o[7:6] == 2'b00) else $error("reserved control bits nonzero");
   cover property (ctrl_wr && !wdata_i[1] && pll_locked_i);
   cover property ($fell(int_reset_o));
   cover property (aux1_clk_en_o && aux2_clk_en_o);
endmodule // clock_reset_control_properties

bind clock_reset_control clock_reset_control_properties i_chk (.mclk_i(mclk_i),
   .srst_i(srst_i), .ext_reset_n_i(ext_reset_n_i), .osc_stable_i(osc_stable_i),
   .main_stable_i(main_stable_i), .pll_locked_i(pll_locked_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .int_reset_o(int_reset_o), .pll_power_down_o(pll_power_down_o),
   .fast_source_select_o(fast_source_select_o), .aux1_clk_en_o(aux1_clk_en_o),
   .aux2_clk_en_o(aux2_clk_en_o));

// ---- tb/clock_reset_control_bench.sv ----
`timescale 1ns/10ps
`include "clock_reset_defines.svh"
// ==========================================================
// directed register and reset sequence bench
module clock_reset_control_bench;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ext_reset_n_i = 1'b0;
   logic osc_stable_i = 1'b0;
   logic main_stable_i = 1'b0;
   logic pll_locked_i = 1'b0;
   logic slow_osc_tick_i = 1'b0;
   logic programming_mode_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [23:0] addr_i = 24'h000000;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic [2:0] pll_mul_o;
   logic int_reset_o, pll_power_down_o, fast_source_select_o, slow_source_select_o;
   logic sys_clk_en_o, slow_clk_en_o, aux1_clk_en_o, aux2_clk_en_o;
   int num_errors = 0;
   int check_count = 0;
   int n_sys, n_a1, n_a2, n_sl, waited;
   initial forever #2.5 mclk_i = ~mclk_i;
   // slow oscillator tick is pulsed by hand to reach the 32k path
   clock_reset_control i_dut (.mclk_i(mclk_i), .srst_i(srst_i),
      .ext_reset_n_i(ext_reset_n_i), .osc_stable_i(osc_stable_i),
      .main_stable_i(main_stable_i), .pll_locked_i(pll_locked_i),
      .slow_osc_tick_i(slow_osc_tick_i),
      .programming_mode_i(programming_mode_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .int_reset_o(int_reset_o),
      .pll_power_down_o(pll_power_down_o), .pll_mul_o(pll_mul_o),
      .fast_source_select_o(fast_source_select_o),
      .slow_source_select_o(slow_source_select_o), .sys_clk_en_o(sys_clk_en_o),
      .slow_clk_en_o(slow_clk_en_o), .aux1_clk_en_o(aux1_clk_en_o),
      .aux2_clk_en_o(aux2_clk_en_o));
   // ==========================================================
   // access tasks
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe, so sample just then
   task rd(input logic [23:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   // any 40-cycle window holds a whole number of divided periods
   task pulses;
      n_sys = 0;
      n_a1 = 0;
      n_a2 = 0;
      n_sl = 0;
      repeat (40) begin
         @(posedge mclk_i);
         #1 n_sys += int'(sys_clk_en_o);
         n_a1 += int'(aux1_clk_en_o);
         n_a2 += int'(aux2_clk_en_o);
         n_sl += int'(slow_clk_en_o);
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (12) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd(`CRC_OFF_CTRL, 8'h26);
      rd(`CRC_OFF_FAST, 8'h4f);
      rd(`CRC_OFF_SLOW, 8'hb6);
      rd(`CRC_OFF_AUX, 8'hff);
      rd(24'hfffc48, 8'h00);
      chk({7'h00, int_reset_o}, 8'h01);
      @(posedge mclk_i);
      osc_stable_i <= 1'b1;
      ext_reset_n_i <= 1'b1;
      main_stable_i <= 1'b1;
      waited = 0;
      while (int_reset_o !== 1'b0 && waited < 20000) begin
         @(posedge mclk_i);
         #1 waited++;
      end
      if (waited >= 20000) begin
         num_errors++;
         summarize();
      end
      chk(8'(waited >= 16383 && waited <= 16390), 8'h01);
      @(posedge mclk_i);
      ext_reset_n_i <= 1'b0;
      @(posedge mclk_i);
      #1 chk({7'h00, int_reset_o}, 8'h01);
      @(posedge mclk_i);
      ext_reset_n_i <= 1'b1;
      wr(`CRC_OFF_CTRL, 8'h26);
      rd(`CRC_OFF_CTRL, 8'h26);
      wr(`CRC_OFF_CTRL, 8'h06);
      rd(`CRC_OFF_CTRL, 8'h06);
      wr(`CRC_OFF_CTRL, 8'h26);
      rd(`CRC_OFF_CTRL, 8'h06);
      wr(`CRC_OFF_CTRL, 8'h04);
      rd(`CRC_OFF_CTRL, 8'h06);
      wr(`CRC_OFF_CTRL, 8'h02);
      #1 chk({7'h00, pll_power_down_o}, 8'h00);
      wr(`CRC_OFF_CTRL, 8'h00);
      rd(`CRC_OFF_CTRL, 8'h02);
      @(posedge mclk_i);
      pll_locked_i <= 1'b1;
      wr(`CRC_OFF_CTRL, 8'h00);
      rd(`CRC_OFF_CTRL, 8'h00);
      chk({7'h00, fast_source_select_o}, 8'h00);
      wr(`CRC_OFF_CTRL, 8'h04);
      rd(`CRC_OFF_CTRL, 8'h00);
      wr(`CRC_OFF_CTRL, 8'h02);
      wr(`CRC_OFF_CTRL, 8'h07);
      rd(`CRC_OFF_CTRL, 8'h07);
      chk({7'h00, slow_source_select_o}, 8'h01);
      // with the oscillator selected the slow enable follows its tick
      @(posedge mclk_i);
      slow_osc_tick_i <= 1'b1;
      #1 chk({7'h00, slow_clk_en_o}, 8'h01);
      @(posedge mclk_i);
      slow_osc_tick_i <= 1'b0;
      #1 chk({7'h00, slow_clk_en_o}, 8'h00);
      wr(`CRC_OFF_AUX, 8'h00);
      wr(`CRC_OFF_SLOW, 8'h04);
      wr(`CRC_OFF_CTRL, 8'h1e);
      // running from main clock, so the prescaler may be rewritten
      for (int m = 3; m <= 5; m++) begin
         wr(`CRC_OFF_FAST, {1'b0, 3'(m), 4'h3});
         rd(`CRC_OFF_FAST, {1'b0, 3'(m), 4'h3});
         chk({5'h00, pll_mul_o}, 8'(m));
      end
      pulses();
      chk(8'(n_sys), 8'd10);
      chk(8'(n_a1), 8'd40);
      chk(8'(n_a2), 8'd40);
      chk(8'(n_sl), 8'd4);
      @(posedge mclk_i);
      main_stable_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      pulses();
      chk(8'(n_a1), 8'd0);
      chk(8'(n_a2), 8'd0);
      @(posedge mclk_i);
      programming_mode_i <= 1'b1;
      srst_i <= 1'b1;
      ext_reset_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd(`CRC_OFF_FAST, 8'h0f);
      chk({7'h00, int_reset_o}, 8'h01);
      summarize();
   end
endmodule // clock_reset_control_bench
